// >>> hw/psram_port_pkg.sv
// Shared constants and carriers for the fabric-side memory port.
// Assumes a 20 MHz system clock that samples all of the controller's clocks.
package psram_port_pkg;

  localparam int DQ_W          = 16;
  localparam int STROBE_W      = 2;
  localparam int FIFO_DEPTH    = 8;
  localparam int SYNC_STAGES   = 3;
  localparam int MEMCLK_MAX_MHZ = 200;
  localparam int LINE_MAX_MBPS = 400;
  localparam int SYS_CLK_MHZ   = 20;
  // A sampled link can only toggle at a fraction of the system clock
  localparam int SAMPLED_MAX_MHZ = SYS_CLK_MHZ / 4;

  localparam logic             RESET_N_ACTIVE = 1'h0;
  localparam logic             CS_N_IDLE      = 1'h1;
  localparam logic [DQ_W-1:0]  DQ_ZERO        = 16'h0000;
  localparam logic [STROBE_W-1:0] STROBE_ZERO = 2'h0;

  // One half-cycle pair of DQ and strobe values
  typedef struct packed {
    logic [DQ_W-1:0]     dq;
    logic [STROBE_W-1:0] strobe;
  } half_word_t;

  // One read beat as captured: rising half, then falling half
  typedef struct packed {
    half_word_t rise;
    half_word_t fall;
  } read_beat_t;

  localparam int BEAT_W = $bits(read_beat_t);

endpackage

// >>> hw/beat_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and one asynchronous active-high reset.
`timescale 1ns/1ps
module beat_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
    ptr_next = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign o_in_ready  = (count_q != (AW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign o_out_data  = mem_q[rd_ptr_q];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= ptr_next(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= ptr_next(rd_ptr_q);
      end
      if (push && !pop) begin
        count_q <= count_q + (AW+1)'(1);
      end else if (pop && !push) begin
        count_q <= count_q - (AW+1)'(1);
      end
    end
  end

endmodule // beat_fifo

// >>> hw/psram_fabric_double_rate_io_register_port.sv
// Fabric-side double-rate port of the embedded pseudo-static memory.
// Assumes the controller's clocks arrive asynchronously and are sampled by i_clk_sys;
// fabric drive values are held stable around the controller clock edges.
`timescale 1ns/1ps

// Behaviour
// [RULE_01] Path carries 16-bit data at double rate, memory clock up to 200 MHz; sampled at 20 MHz, the port follows only up to 5 MHz (SAMPLED_MAX_MHZ).
// [RULE_02] Controller supplies its clock and a 90-degree shifted copy.
// [RULE_03] Controller supplies a calibration clock used to capture read data.
// [RULE_04] Memory reset is active low; low resets, high for normal operation.
// [RULE_05] Chip select is active low over a transaction, high while idle.
// [RULE_06] Differential memory clock driven as half-cycle values; may stop between bursts.
// [RULE_07] Write strobe halves act as byte mask through double-rate registers.
// [RULE_08] Strobe enable asserted only while controller drives strobe.
// [RULE_09] Memory strobe returned as halves: latency cue, then read reference.
// [RULE_10] Command, address and write data sent over 16-bit DQ halves.
// [RULE_11] DQ output enable per bit; released so memory can return data.
// [RULE_12] Read data delivered as 16-bit halves, one per memory clock edge.
// [RULE_13] High half launched on rising edge, low half on next falling edge.
module psram_fabric_double_rate_io_register_port #(
  parameter int DQ_W       = psram_port_pkg::DQ_W, // RULE_01
  parameter int STROBE_W   = psram_port_pkg::STROBE_W,
  parameter int FIFO_DEPTH = psram_port_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic                i_clk_sys,
  input  wire logic                i_reset,
  // Controller clocks (sampled)
  input  wire logic                i_ctrl_clock,
  input  wire logic                i_quadrature_ctrl_clock,
  input  wire logic                i_read_capture_cal_clock,
  // Controller control
  input  wire logic                i_mem_reset_n,
  input  wire logic                i_mem_cs_n,
  input  wire logic                i_memclk_true_rise,
  input  wire logic                i_memclk_true_fall,
  input  wire logic                i_memclk_comp_rise,
  input  wire logic                i_memclk_comp_fall,
  // Controller write path
  input  wire logic [STROBE_W-1:0] i_strobe_drive_rise,
  input  wire logic [STROBE_W-1:0] i_strobe_drive_fall,
  input  wire logic [STROBE_W-1:0] i_strobe_drive_enable,
  input  wire logic [DQ_W-1:0]     i_bus_drive_rise,
  input  wire logic [DQ_W-1:0]     i_bus_drive_fall,
  input  wire logic [DQ_W-1:0]     i_bus_drive_enable,
  // Controller read path
  output logic [STROBE_W-1:0]      o_strobe_sense_rise,
  output logic [STROBE_W-1:0]      o_strobe_sense_fall,
  output logic [DQ_W-1:0]          o_bus_sense_rise,
  output logic [DQ_W-1:0]          o_bus_sense_fall,
  output logic                     o_read_valid,
  input  wire logic                i_read_ready,
  output logic                     o_capture_ready,
  output logic                     o_read_overrun,
  input  wire logic                i_overrun_clear,
  // Memory pins
  output logic                     o_mem_reset_n,
  output logic                     o_mem_cs_n,
  output logic                     o_mem_ck_p,
  output logic                     o_mem_ck_n,
  output logic [STROBE_W-1:0]      o_mem_strobe,
  output logic [STROBE_W-1:0]      o_mem_strobe_oe,
  input  wire logic [STROBE_W-1:0] i_mem_strobe,
  output logic [DQ_W-1:0]          o_mem_dq,
  output logic [DQ_W-1:0]          o_mem_dq_oe,
  input  wire logic [DQ_W-1:0]     i_mem_dq
);

  localparam int CLK_N = 3;
  localparam int PIN_W = DQ_W + STROBE_W;

  // Clock sampling: three stages, a level changes when stages two and three agree
  logic [CLK_N-1:0] clk_s1_q;
  logic [CLK_N-1:0] clk_s2_q;
  logic [CLK_N-1:0] clk_s3_q;
  logic [CLK_N-1:0] clk_lvl_q;
  logic [CLK_N-1:0] clk_rise;
  logic [CLK_N-1:0] clk_fall;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      clk_s1_q  <= '0;
      clk_s2_q  <= '0;
      clk_s3_q  <= '0;
      clk_lvl_q <= '0;
    end else begin
      clk_s1_q  <= {i_read_capture_cal_clock, i_quadrature_ctrl_clock, i_ctrl_clock};
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      for (int k = 0; k < CLK_N; k++) begin
        if (clk_s2_q[k] == clk_s3_q[k]) begin
          clk_lvl_q[k] <= clk_s3_q[k];
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < CLK_N; k++) begin
      clk_rise[k] = (clk_s2_q[k] == clk_s3_q[k]) && clk_s3_q[k] && !clk_lvl_q[k];
      clk_fall[k] = (clk_s2_q[k] == clk_s3_q[k]) && !clk_s3_q[k] && clk_lvl_q[k];
    end
  end

  logic ctl_rise;
  logic ctl_fall;
  logic quad_rise;
  logic quad_fall;
  logic cal_rise;
  logic cal_fall;
  assign ctl_rise  = clk_rise[0]; // RULE_02
  assign ctl_fall  = clk_fall[0];
  assign quad_rise = clk_rise[1]; // RULE_02
  assign quad_fall = clk_fall[1];
  assign cal_rise  = clk_rise[2]; // RULE_03
  assign cal_fall  = clk_fall[2];

  // Memory pins also pass three stages, keeping data aligned with the sampled edges
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  psram_port_pkg::half_word_t pin_now;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= {i_mem_dq, i_mem_strobe};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end
  assign pin_now = psram_port_pkg::half_word_t'(pin_s3_q);

  // Reset and select follow the controller directly; defaults keep memory in reset and idle
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_mem_reset_n <= psram_port_pkg::RESET_N_ACTIVE; // RULE_04
      o_mem_cs_n    <= psram_port_pkg::CS_N_IDLE;      // RULE_05
    end else begin
      o_mem_reset_n <= i_mem_reset_n;                  // RULE_04
      o_mem_cs_n    <= i_mem_cs_n;                     // RULE_05
    end
  end

  // Memory clock rides the quadrature edges so it lands mid-way in the data eye
  logic ck_p_fall_q;
  logic ck_n_fall_q;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_mem_ck_p  <= 1'h0;
      o_mem_ck_n  <= 1'h1;
      ck_p_fall_q <= 1'h0;
      ck_n_fall_q <= 1'h1;
    end else if (quad_rise) begin
      o_mem_ck_p  <= i_memclk_true_rise; // RULE_06
      o_mem_ck_n  <= i_memclk_comp_rise; // RULE_13
      ck_p_fall_q <= i_memclk_true_fall;
      ck_n_fall_q <= i_memclk_comp_fall;
    end else if (quad_fall) begin
      o_mem_ck_p  <= ck_p_fall_q;        // RULE_06
      o_mem_ck_n  <= ck_n_fall_q;        // RULE_13
    end
  end

  // Write path: both halves taken at the rising edge, low half held for the falling one
  logic [DQ_W-1:0]     dq_fall_q;
  logic [STROBE_W-1:0] strobe_fall_q;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_mem_dq        <= psram_port_pkg::DQ_ZERO;
      o_mem_dq_oe     <= psram_port_pkg::DQ_ZERO;
      dq_fall_q       <= psram_port_pkg::DQ_ZERO;
      o_mem_strobe    <= psram_port_pkg::STROBE_ZERO;
      o_mem_strobe_oe <= psram_port_pkg::STROBE_ZERO;
      strobe_fall_q   <= psram_port_pkg::STROBE_ZERO;
    end else if (ctl_rise) begin
      o_mem_dq        <= i_bus_drive_rise;      // RULE_10
      o_mem_dq_oe     <= i_bus_drive_enable;    // RULE_11
      dq_fall_q       <= i_bus_drive_fall;      // RULE_13
      o_mem_strobe    <= i_strobe_drive_rise;   // RULE_07
      o_mem_strobe_oe <= i_strobe_drive_enable; // RULE_08
      strobe_fall_q   <= i_strobe_drive_fall;
    end else if (ctl_fall) begin
      o_mem_dq        <= dq_fall_q;             // RULE_13
      o_mem_strobe    <= strobe_fall_q;         // RULE_07
    end
  end

  // Strobe sense halves track the memory always, for latency cues during the command phase
  psram_port_pkg::half_word_t rise_hold_q;
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_strobe_sense_rise <= psram_port_pkg::STROBE_ZERO;
      o_strobe_sense_fall <= psram_port_pkg::STROBE_ZERO;
      rise_hold_q         <= '0;
    end else if (cal_rise) begin
      rise_hold_q         <= pin_now;        // RULE_13
      o_strobe_sense_rise <= pin_now.strobe; // RULE_09
    end else if (cal_fall) begin
      o_strobe_sense_fall <= pin_now.strobe; // RULE_09
    end
  end

  // A beat is queued at the falling half only while the controller has released DQ
  psram_port_pkg::read_beat_t beat_in;
  psram_port_pkg::read_beat_t beat_out;
  logic                       push_valid;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;
  logic [psram_port_pkg::BEAT_W-1:0] fifo_out_data;

  assign beat_in.rise = rise_hold_q;
  assign beat_in.fall = pin_now;
  assign push_valid   = cal_fall && (o_mem_dq_oe == psram_port_pkg::DQ_ZERO); // RULE_11

  beat_fifo #(
    .WIDTH (psram_port_pkg::BEAT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_beat_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_reset     (i_reset),
    .i_in_valid  (push_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (beat_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  assign beat_out       = psram_port_pkg::read_beat_t'(fifo_out_data);
  assign fifo_out_ready = !o_read_valid || i_read_ready;

  // Output stage keeps the read halves on flip-flops; a stalled reader fills the FIFO
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_read_valid     <= 1'h0;
      o_bus_sense_rise <= psram_port_pkg::DQ_ZERO;
      o_bus_sense_fall <= psram_port_pkg::DQ_ZERO;
    end else if (fifo_out_ready) begin
      o_read_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        o_bus_sense_rise <= beat_out.rise.dq; // RULE_12
        o_bus_sense_fall <= beat_out.fall.dq; // RULE_12
      end
    end
  end

  // The memory cannot be stalled; the controller must stop the clock when ready drops
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_capture_ready <= 1'h0;
      o_read_overrun  <= 1'h0;
    end else begin
      o_capture_ready <= fifo_in_ready;
      if (push_valid && !fifo_in_ready) begin
        o_read_overrun <= 1'h1;
      end else if (i_overrun_clear) begin
        o_read_overrun <= 1'h0;
      end
    end
  end

endmodule // psram_fabric_double_rate_io_register_port

// >>> tb/psram_port_assertions.sv
// Concurrent checks on the memory port's pin drives and read handshake.
// Bound into every port instance; one clock domain with async reset.
`timescale 1ns/1ps
module psram_port_assertions #(
  parameter int DQ_W     = 16,
  parameter int STROBE_W = 2
) (
  // Clock and reset
  input wire logic                i_clk_sys,
  input wire logic                i_reset,
  // Controller side
  input wire logic                i_ctrl_clock,
  input wire logic                i_quadrature_ctrl_clock,
  input wire logic                i_mem_reset_n,
  input wire logic                i_mem_cs_n,
  input wire logic                i_memclk_true_rise,
  input wire logic                i_memclk_comp_fall,
  input wire logic [STROBE_W-1:0] i_strobe_drive_enable,
  input wire logic [DQ_W-1:0]     i_bus_drive_rise,
  input wire logic [DQ_W-1:0]     i_bus_drive_fall,
  input wire logic [DQ_W-1:0]     i_bus_drive_enable,
  input wire logic                i_read_ready,
  input wire logic                i_overrun_clear,
  // Port outputs
  input wire logic                o_read_valid,
  input wire logic [DQ_W-1:0]     o_bus_sense_rise,
  input wire logic                o_read_overrun,
  input wire logic                o_mem_reset_n,
  input wire logic                o_mem_cs_n,
  input wire logic                o_mem_ck_p,
  input wire logic                o_mem_ck_n,
  input wire logic [STROBE_W-1:0] o_mem_strobe_oe,
  input wire logic [DQ_W-1:0]     o_mem_dq,
  input wire logic [DQ_W-1:0]     o_mem_dq_oe
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // The sampled clock level two edges back tells which half a launch belongs to
  sequence s_dq_hi; $changed(o_mem_dq) && $past(i_ctrl_clock, 2); endsequence
  sequence s_dq_lo; $changed(o_mem_dq) && !$past(i_ctrl_clock, 2); endsequence
  property p_rst; !$past(i_reset) |-> o_mem_reset_n == $past(i_mem_reset_n); endproperty
  property p_cs; !$past(i_reset) |-> o_mem_cs_n == $past(i_mem_cs_n); endproperty
  property p_dq_oe;
    $changed(o_mem_dq_oe) |-> $past(i_ctrl_clock, 2) && o_mem_dq_oe == $past(i_bus_drive_enable);
  endproperty
  property p_st_oe;
    $changed(o_mem_strobe_oe) |-> $past(i_ctrl_clock, 2)
      && o_mem_strobe_oe == $past(i_strobe_drive_enable);
  endproperty
  property p_dq_hi; s_dq_hi |-> o_mem_dq == $past(i_bus_drive_rise); endproperty
  property p_dq_lo; s_dq_lo |-> o_mem_dq == $past(i_bus_drive_fall); endproperty
  property p_ck_hi;
    $changed(o_mem_ck_p) && $past(i_quadrature_ctrl_clock, 2)
      |-> o_mem_ck_p == $past(i_memclk_true_rise);
  endproperty
  property p_ck_lo;
    $changed(o_mem_ck_n) && !$past(i_quadrature_ctrl_clock, 2)
      |-> o_mem_ck_n == $past(i_memclk_comp_fall);
  endproperty
  property p_hold;
    o_read_valid && !i_read_ready |=> o_read_valid && $stable(o_bus_sense_rise);
  endproperty
  property p_ovr; o_read_overrun && !i_overrun_clear |=> o_read_overrun; endproperty
  a_rst: assert property (p_rst) else $error("memory reset copy wrong");
  a_cs: assert property (p_cs) else $error("chip select copy wrong");
  a_dq_oe: assert property (p_dq_oe) else $error("bus enable launch wrong");
  a_st_oe: assert property (p_st_oe) else $error("strobe enable launch wrong");
  a_dq_hi: assert property (p_dq_hi) else $error("rise half wrong");
  a_dq_lo: assert property (p_dq_lo) else $error("fall half wrong");
  a_ck_hi: assert property (p_ck_hi) else $error("true leg wrong");
  a_ck_lo: assert property (p_ck_lo) else $error("complement leg wrong");
  a_hold: assert property (p_hold) else $error("read beat not held");
  a_ovr: assert property (p_ovr) else $error("overrun flag lost");
endmodule // psram_port_assertions

bind psram_fabric_double_rate_io_register_port psram_port_assertions #(
  .DQ_W     (DQ_W),
  .STROBE_W (STROBE_W)
) chk_u (
  .i_clk_sys               (i_clk_sys),
  .i_reset                 (i_reset),
  .i_ctrl_clock            (i_ctrl_clock),
  .i_quadrature_ctrl_clock (i_quadrature_ctrl_clock),
  .i_mem_reset_n           (i_mem_reset_n),
  .i_mem_cs_n              (i_mem_cs_n),
  .i_memclk_true_rise      (i_memclk_true_rise),
  .i_memclk_comp_fall      (i_memclk_comp_fall),
  .i_strobe_drive_enable   (i_strobe_drive_enable),
  .i_bus_drive_rise        (i_bus_drive_rise),
  .i_bus_drive_fall        (i_bus_drive_fall),
  .i_bus_drive_enable      (i_bus_drive_enable),
  .i_read_ready            (i_read_ready),
  .i_overrun_clear         (i_overrun_clear),
  .o_read_valid            (o_read_valid),
  .o_bus_sense_rise        (o_bus_sense_rise),
  .o_read_overrun          (o_read_overrun),
  .o_mem_reset_n           (o_mem_reset_n),
  .o_mem_cs_n              (o_mem_cs_n),
  .o_mem_ck_p              (o_mem_ck_p),
  .o_mem_ck_n              (o_mem_ck_n),
  .o_mem_strobe_oe         (o_mem_strobe_oe),
  .o_mem_dq                (o_mem_dq),
  .o_mem_dq_oe             (o_mem_dq_oe)
);

// >>> tb/fabric_ctrl_model.sv
// Behavioural fabric controller clocks: controller, quadrature and capture.
// One 400 ns period per frame request; between frames all clocks stand low.
`timescale 1ns/1ps
module fabric_ctrl_model (
  // Frame request
  input  wire logic i_run,
  // Clocks to the port
  output logic      o_ctrl_clock,
  output logic      o_quad_clock,
  output logic      o_cal_clock
);
  initial begin
    o_ctrl_clock = 1'h0;
    o_quad_clock = 1'h0;
    o_cal_clock  = 1'h0;
    forever begin
      wait (i_run);
      // Odd offset keeps the edges off the system clock grid
      #117;
      o_ctrl_clock = 1'h1;
      #100;
      o_quad_clock = 1'h1;
      o_cal_clock  = 1'h1;
      #100;
      o_ctrl_clock = 1'h0;
      #100;
      o_quad_clock = 1'h0;
      o_cal_clock  = 1'h0;
      #100;
    end
  end
endmodule // fabric_ctrl_model

// >>> tb/testbench.sv
// Self-checking bench for the memory port, with a queue model of read beats.
// Assumes the port, its package, FIFO and the clock model are compiled first.
`timescale 1ns/1ps
module testbench;
  logic        i_clk_sys, i_reset, i_ctrl_clock, i_quadrature_ctrl_clock, i_read_capture_cal_clock;
  logic        i_mem_reset_n, i_mem_cs_n, i_memclk_true_rise, i_memclk_true_fall, run, exp_ovr;
  logic        i_memclk_comp_rise, i_memclk_comp_fall, i_read_ready, i_overrun_clear;
  logic [1:0]  i_strobe_drive_rise, i_strobe_drive_fall, i_strobe_drive_enable, i_mem_strobe;
  logic [15:0] i_bus_drive_rise, i_bus_drive_fall, i_bus_drive_enable, i_mem_dq;
  logic [1:0]  o_strobe_sense_rise, o_strobe_sense_fall, o_mem_strobe, o_mem_strobe_oe, rdy_mode;
  logic [15:0] o_bus_sense_rise, o_bus_sense_fall, o_mem_dq, o_mem_dq_oe;
  logic        o_read_valid, o_capture_ready, o_read_overrun, o_mem_reset_n, o_mem_cs_n;
  logic        o_mem_ck_p, o_mem_ck_n;
  logic [31:0] exp_q[$];
  logic [31:0] e;
  int          fails = 0;
  int          n_tests = 0;

  psram_fabric_double_rate_io_register_port dut_u (
    .i_clk_sys                (i_clk_sys),
    .i_reset                  (i_reset),
    .i_ctrl_clock             (i_ctrl_clock),
    .i_quadrature_ctrl_clock  (i_quadrature_ctrl_clock),
    .i_read_capture_cal_clock (i_read_capture_cal_clock),
    .i_mem_reset_n            (i_mem_reset_n),
    .i_mem_cs_n               (i_mem_cs_n),
    .i_memclk_true_rise       (i_memclk_true_rise),
    .i_memclk_true_fall       (i_memclk_true_fall),
    .i_memclk_comp_rise       (i_memclk_comp_rise),
    .i_memclk_comp_fall       (i_memclk_comp_fall),
    .i_strobe_drive_rise      (i_strobe_drive_rise),
    .i_strobe_drive_fall      (i_strobe_drive_fall),
    .i_strobe_drive_enable    (i_strobe_drive_enable),
    .i_bus_drive_rise         (i_bus_drive_rise),
    .i_bus_drive_fall         (i_bus_drive_fall),
    .i_bus_drive_enable       (i_bus_drive_enable),
    .o_strobe_sense_rise      (o_strobe_sense_rise),
    .o_strobe_sense_fall      (o_strobe_sense_fall),
    .o_bus_sense_rise         (o_bus_sense_rise),
    .o_bus_sense_fall         (o_bus_sense_fall),
    .o_read_valid             (o_read_valid),
    .i_read_ready             (i_read_ready),
    .o_capture_ready          (o_capture_ready),
    .o_read_overrun           (o_read_overrun),
    .i_overrun_clear          (i_overrun_clear),
    .o_mem_reset_n            (o_mem_reset_n),
    .o_mem_cs_n               (o_mem_cs_n),
    .o_mem_ck_p               (o_mem_ck_p),
    .o_mem_ck_n               (o_mem_ck_n),
    .o_mem_strobe             (o_mem_strobe),
    .o_mem_strobe_oe          (o_mem_strobe_oe),
    .i_mem_strobe             (i_mem_strobe),
    .o_mem_dq                 (o_mem_dq),
    .o_mem_dq_oe              (o_mem_dq_oe),
    .i_mem_dq                 (i_mem_dq)
  );
  fabric_ctrl_model ctrl_u (.i_run(run), .o_ctrl_clock(i_ctrl_clock),
    .o_quad_clock(i_quadrature_ctrl_clock), .o_cal_clock(i_read_capture_cal_clock));

  always #25 i_clk_sys = ~i_clk_sys;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Reader: random, stalled or always ready; every accepted beat is compared
  always @(posedge i_clk_sys) begin
    i_read_ready <= (rdy_mode == 2'h2) ? 1'($urandom_range(1)) : rdy_mode[0];
    if (!i_reset && o_read_valid === 1'h1 && i_read_ready === 1'h1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx;
      chk(o_bus_sense_rise, e[31:16]);
      chk(o_bus_sense_fall, e[15:0]);
    end
  end

  // One controller clock period: write drive out, memory data back
  task automatic xfer(input logic rd);
    logic [15:0] mr, mf, oe;
    logic [1:0]  msr, msf;
    mr = 16'($urandom);
    mf = 16'($urandom);
    msr = 2'($urandom);
    msf = 2'($urandom);
    oe = (rd || $urandom_range(1) == 1) ? 16'h0 : 16'($urandom);
    @(posedge i_clk_sys);
    i_bus_drive_rise <= 16'($urandom);
    i_bus_drive_fall <= 16'($urandom);
    i_bus_drive_enable <= oe;
    i_strobe_drive_rise <= 2'($urandom);
    i_strobe_drive_fall <= 2'($urandom);
    i_strobe_drive_enable <= 2'($urandom);
    {i_memclk_true_rise, i_memclk_true_fall} <= 2'($urandom);
    {i_memclk_comp_rise, i_memclk_comp_fall} <= 2'($urandom);
    {i_mem_reset_n, i_mem_cs_n} <= 2'($urandom);
    i_mem_dq <= mr;
    i_mem_strobe <= msr;
    run <= 1'h1;
    @(posedge i_ctrl_clock);
    @(posedge i_clk_sys);
    run <= 1'h0;
    repeat (4) @(posedge i_clk_sys);
    i_mem_dq <= mf;
    i_mem_strobe <= msf;
    repeat (2) @(negedge i_clk_sys);
    chk(o_mem_dq, i_bus_drive_rise);
    chk(o_mem_dq_oe, oe);
    chk(16'(o_mem_strobe), 16'(i_strobe_drive_rise));
    chk(16'(o_mem_strobe_oe), 16'(i_strobe_drive_enable));
    chk(16'({o_mem_ck_p, o_mem_ck_n}), 16'({i_memclk_true_rise, i_memclk_comp_rise}));
    chk(16'({o_mem_reset_n, o_mem_cs_n}), 16'({i_mem_reset_n, i_mem_cs_n}));
    chk(16'(o_strobe_sense_rise), 16'(msr));
    if (oe == 16'h0) begin
      if (exp_q.size() < 9) exp_q.push_back({mr, mf});
      else exp_ovr = 1'h1;
    end
    repeat (4) @(negedge i_clk_sys);
    chk(o_mem_dq, i_bus_drive_fall);
    chk(16'(o_mem_strobe), 16'(i_strobe_drive_fall));
    chk(16'({o_mem_ck_p, o_mem_ck_n}), 16'({i_memclk_true_fall, i_memclk_comp_fall}));
    chk(16'(o_strobe_sense_fall), 16'(msf));
  endtask

  initial begin
    void'($urandom(27));
    {i_clk_sys, run, exp_ovr, i_overrun_clear, rdy_mode} = '0;
    i_reset = 1'h1;
    {i_memclk_true_rise, i_memclk_true_fall, i_memclk_comp_rise, i_memclk_comp_fall} = 4'h0;
    {i_strobe_drive_rise, i_strobe_drive_fall, i_strobe_drive_enable, i_mem_strobe} = 8'h0;
    {i_bus_drive_rise, i_bus_drive_fall, i_bus_drive_enable, i_mem_dq} = 64'h0;
    i_mem_reset_n = 1'h0;
    i_mem_cs_n = 1'h1;
    repeat (10) @(posedge i_clk_sys);
    chk(16'({o_mem_reset_n, o_mem_cs_n, o_mem_ck_p, o_mem_ck_n}), 16'h5);
    i_reset <= 1'h0;
    rdy_mode <= 2'h2;
    repeat (30) xfer(1'h0);
    rdy_mode <= 2'h0;
    // Stalled reader: fill until the port refuses and flags the loss
    repeat (10) xfer(1'h1);
    chk(16'({o_read_overrun, o_capture_ready}), 16'({exp_ovr, 1'h0}));
    @(posedge i_clk_sys);
    i_overrun_clear <= 1'h1;
    @(posedge i_clk_sys);
    i_overrun_clear <= 1'h0;
    rdy_mode <= 2'h1;
    repeat (40) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk(16'({o_read_overrun, o_read_valid, o_capture_ready}), 16'h1);
    chk(16'(exp_q.size()), 16'h0);
    give_verdict();
  end

  initial begin
    #200_000;
    fails++;
    give_verdict();
  end
endmodule // testbench
